// File: tbsp_cfg.svh
// Purpose: Constants of the 10 Mb/s transceiver controller-side serial port.
// Assumes: i_clk at 250 MHz; all times below are in ns unless named otherwise.
// Notes:   Cycle counts derive from the times and the clock period.
`ifndef TBSP_CFG_SVH
`define TBSP_CFG_SVH

`define TBSP_CLK_NS          4
`define TBSP_BIT_NS          100
`define TBSP_MIN_PULSE_NS    40
`define TBSP_MID_NS          75
`define TBSP_IDLE_NS         200
`define TBSP_COL_HOLD_NS     200
`define TBSP_SQE_DELAY_NS    1000
`define TBSP_SQE_LEN_NS      1000
`define TBSP_JABBER_MS       20

// The least pulse width rounds up; all other times, the mid-cell time among them, round down
`define TBSP_BIT_CYC         (`TBSP_BIT_NS / `TBSP_CLK_NS)
`define TBSP_HALF_CYC        (`TBSP_BIT_CYC / 2)
`define TBSP_MIN_CYC         ((`TBSP_MIN_PULSE_NS + `TBSP_CLK_NS - 1) / `TBSP_CLK_NS)
`define TBSP_MID_CYC         (`TBSP_MID_NS / `TBSP_CLK_NS)
`define TBSP_IDLE_CYC        (`TBSP_IDLE_NS / `TBSP_CLK_NS)
`define TBSP_COL_HOLD_CYC    (`TBSP_COL_HOLD_NS / `TBSP_CLK_NS)
`define TBSP_SQE_DELAY_CYC   (`TBSP_SQE_DELAY_NS / `TBSP_CLK_NS)
`define TBSP_SQE_LEN_CYC     (`TBSP_SQE_LEN_NS / `TBSP_CLK_NS)
`define TBSP_JABBER_CYC      ((`TBSP_JABBER_MS * 1000000) / `TBSP_CLK_NS)

`define TBSP_CNT_W           9
`define TBSP_JAB_W           23
`define TBSP_SQ_LAST         2'h2
`define TBSP_RX_FIFO_W       1
`define TBSP_RX_FIFO_D       16

// Line pair bit positions and idle levels
`define TBSP_PAIR_POS        1
`define TBSP_PAIR_NEG        0
`define TBSP_PAIR_IDLE_HIGH  2'h3
`define TBSP_PAIR_QUIET      2'h0

`endif

// File: tbsp_ctrl_model.sv
// Purpose: Controller model driving the transmit side of the serial port.
// Assumes: Data and enable change 1 ns after each transmit clock rise.
// Notes:   Receive outputs are not read by this model.
module tbsp_ctrl_model (
  // Clock from the device
  input  wire logic       i_transmit_clock,
  // Test control
  input  wire logic       i_go,
  input  wire logic [7:0] i_pattern,
  // Lines to the device
  output logic            o_transmit_enable,
  output logic            o_transmit_data
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned idx = 0;
  // Enable already high when reset ends
  initial o_transmit_enable = 1'b1;
  initial o_transmit_data = 1'b0;
  // Receive data left unused, so nothing is trusted before lock
  // Changes only just after a transmit clock rise
  always @(posedge i_transmit_clock) begin
    #1;
    o_transmit_enable = i_go;
    o_transmit_data   = i_go ? i_pattern[idx[2:0]] : ~o_transmit_data;
    idx = i_go ? idx + 1 : 0;
  end
endmodule

// File: tbsp_fifo.sv
// Purpose: Elastic FIFO between receive decoder and recovered clock.
// Assumes: DEPTH is a power of two.
// Notes:   Read data come from a register; one word of extra latency.
module tbsp_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  // Drain side
  input  wire logic             i_ready,
  output logic                  o_valid,
  output logic      [WIDTH-1:0] o_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;

  wire push = i_valid & o_ready;
  wire load = (count != '0) & (~o_valid | i_ready);

  assign o_ready    = count != (AW+1)'(DEPTH);
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
      rd_ptr <= load ? rd_ptr + AW'(1) : rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data  <= '0;
    end else if (load) begin
      o_valid <= 1'b1;
      o_data  <= mem[rd_ptr];
    end else if (i_ready) begin
      o_valid <= 1'b0;
    end
  end

endmodule

// File: tbsp_pkg.sv
// Purpose: Types of the transceiver serial port.
// Assumes: One-hot state codes.
// Notes:   Constants live in tbsp_cfg.svh.
package tbsp_pkg;

  typedef enum logic [2:0] {
    TBSP_TX_IDLE   = 3'h1,
    TBSP_TX_FIRST  = 3'h2,
    TBSP_TX_SECOND = 3'h4
  } tbsp_tx_state_t;

  typedef enum logic [2:0] {
    TBSP_RX_IDLE = 3'h1,
    TBSP_RX_QUAL = 3'h2,
    TBSP_RX_DATA = 3'h4
  } tbsp_rx_state_t;

endpackage

// File: tbsp_port.sv
// Purpose: Controller-side serial port of a 10 Mb/s transceiver.
// Assumes: Line comparator results arrive as synchronous logic levels.
// Notes:   Pairs carry {positive, negative}; outputs float via o_ctrl_oe.
`include "tbsp_cfg.svh"

module tbsp_port #(
  parameter int unsigned JABBER_CYC = `TBSP_JABBER_CYC
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Oscillator, 20 MHz, sampled
  input  wire logic       i_osc,
  // Mode selection
  input  wire logic       i_standby,
  input  wire logic       i_aui_select,
  input  wire logic       i_auto_select,
  input  wire logic       i_heartbeat_enable,
  // Controller interface
  input  wire logic       i_transmit_data,
  input  wire logic       i_transmit_enable,
  output logic            o_transmit_clock,
  output logic            o_receive_clock,
  output logic            o_receive_data,
  output logic            o_receive_activity,
  output logic            o_collision_indicator,
  output logic            o_ctrl_oe,
  output logic            o_transmit_enable_pulldown,
  // AUI line side
  input  wire logic [1:0] i_aui_receive_pair,
  input  wire logic       i_aui_rx_carrier,
  input  wire logic [1:0] i_aui_collision_pair,
  input  wire logic       i_aui_col_threshold,
  output logic      [1:0] o_aui_transmit_pair,
  // Twisted pair line side
  input  wire logic [1:0] i_twisted_receive_pair,
  input  wire logic       i_tp_rx_threshold,
  output logic      [1:0] o_twisted_transmit_pair
);

  localparam logic [8:0] BIT_CYC   = 9'(`TBSP_BIT_CYC);
  localparam logic [8:0] HALF_CYC  = 9'(`TBSP_HALF_CYC);
  localparam logic [8:0] MIN_CYC   = 9'(`TBSP_MIN_CYC);
  localparam logic [8:0] MID_CYC   = 9'(`TBSP_MID_CYC);
  localparam logic [8:0] IDLE_CYC  = 9'(`TBSP_IDLE_CYC);
  localparam logic [8:0] HOLD_CYC  = 9'(`TBSP_COL_HOLD_CYC);
  localparam logic [8:0] SQE_LEN   = 9'(`TBSP_SQE_LEN_CYC);
  localparam logic [8:0] SQE_TOTAL = 9'(`TBSP_SQE_DELAY_CYC + `TBSP_SQE_LEN_CYC);
  localparam logic [8:0] CNT_MAX   = '1;
  localparam logic [22:0] JAB_LAST = 23'(JABBER_CYC - 1);

  function automatic logic pair_level(input logic [1:0] pair);
    pair_level = pair[`TBSP_PAIR_POS] & ~pair[`TBSP_PAIR_NEG];
  endfunction

  function automatic logic [8:0] sat_inc(input logic [8:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + 9'h001;
  endfunction

  function automatic logic [8:0] dec_floor(input logic [8:0] v);
    dec_floor = (v == 9'h000) ? v : v - 9'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Transmit clock and encoder

  tbsp_pkg::tbsp_tx_state_t enc_state;
  tbsp_pkg::tbsp_tx_state_t next_enc_state;
  logic        osc_q;
  logic        armed;
  logic        jabbered;
  logic        bit_hold;
  logic        sym;
  logic [22:0] jab_cnt;

  wire osc_rise  = i_osc & ~osc_q;
  wire tx_rise   = osc_rise & ~o_transmit_clock;
  wire tx_mid    = osc_rise & o_transmit_clock;
  wire en_s      = i_transmit_enable & ~i_standby;
  wire tx_active = enc_state != tbsp_pkg::TBSP_TX_IDLE;
  wire jab_hit   = tx_active & ~i_aui_select & (jab_cnt == JAB_LAST);
  wire tx_start  = tx_rise & en_s & armed & ~jabbered & ~jab_hit;

  always_comb begin
    next_enc_state = enc_state;
    unique case (enc_state)
      tbsp_pkg::TBSP_TX_IDLE: begin
        if (tx_start) begin
          next_enc_state = tbsp_pkg::TBSP_TX_FIRST;
        end
      end
      tbsp_pkg::TBSP_TX_FIRST: begin
        if (jab_hit) begin
          next_enc_state = tbsp_pkg::TBSP_TX_IDLE;
        end else if (tx_mid) begin
          next_enc_state = tbsp_pkg::TBSP_TX_SECOND;
        end
      end
      tbsp_pkg::TBSP_TX_SECOND: begin
        if (jab_hit || tx_rise) begin
          next_enc_state = tx_start ? tbsp_pkg::TBSP_TX_FIRST : tbsp_pkg::TBSP_TX_IDLE;
        end
      end
    endcase
  end

  // Transmit clock toggles on each oscillator rise
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_q            <= 1'b0;
      o_transmit_clock <= 1'b0;
    end else begin
      osc_q            <= i_osc;
      o_transmit_clock <= osc_rise ? ~o_transmit_clock : o_transmit_clock;
    end
  end

  // Enable is sampled only on the transmit clock rise
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      armed <= 1'b0;
    end else if (tx_rise && !en_s) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      enc_state <= tbsp_pkg::TBSP_TX_IDLE;
      bit_hold  <= 1'b0;
      sym       <= 1'b0;
    end else begin
      enc_state <= next_enc_state;
      if (tx_start) begin
        bit_hold <= i_transmit_data;
        sym      <= ~i_transmit_data;
      end else if (tx_mid && enc_state == tbsp_pkg::TBSP_TX_FIRST) begin
        sym <= bit_hold;
      end
    end
  end

  // Jabber stops a twisted pair frame that runs too long until enable drops; AUI frames are not timed
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      jab_cnt  <= '0;
      jabbered <= 1'b0;
    end else begin
      jab_cnt <= tx_active ? jab_cnt + 23'h000001 : '0;
      if (jab_hit) begin
        jabbered <= 1'b1;
      end else if (tx_rise && !en_s) begin
        jabbered <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Heartbeat after each frame on the twisted pair

  logic       tx_active_q;
  logic [8:0] sqe_cnt;

  wire tx_end = tx_active_q & ~tx_active;
  wire sqe_on = (sqe_cnt != 9'h000) & (sqe_cnt <= SQE_LEN);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_active_q <= 1'b0;
      sqe_cnt     <= '0;
    end else begin
      tx_active_q <= tx_active;
      sqe_cnt     <= (tx_end && i_heartbeat_enable && !i_aui_select) ? SQE_TOTAL
                                                                     : dec_floor(sqe_cnt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive qualification and decoding

  tbsp_pkg::tbsp_rx_state_t dec_state;
  tbsp_pkg::tbsp_rx_state_t next_dec_state;
  logic       line_q;
  logic [8:0] wcnt;
  logic [8:0] mcnt;
  logic [1:0] pulses;
  logic       rx_room;

  wire [1:0] rx_pair    = i_aui_select ? i_aui_receive_pair : i_twisted_receive_pair;
  wire       rx_line    = pair_level(rx_pair);
  wire       rx_thr     = i_aui_select ? i_aui_rx_carrier : i_tp_rx_threshold;
  wire       rx_edge    = rx_line ^ line_q;
  wire       long_pulse = wcnt >= MIN_CYC;
  wire       rx_quiet   = wcnt >= IDLE_CYC;
  wire       mid_edge   = rx_edge & (mcnt >= MID_CYC);
  wire       rx_carrier = dec_state == tbsp_pkg::TBSP_RX_DATA;
  wire       rx_push    = rx_carrier & mid_edge & rx_room;
  wire       rx_enter   = ~rx_carrier & (next_dec_state == tbsp_pkg::TBSP_RX_DATA);

  // Noise and short pulses never reach the data state; pulse width is not checked once in it
  always_comb begin
    next_dec_state = dec_state;
    unique case (dec_state)
      tbsp_pkg::TBSP_RX_IDLE: begin
        if (rx_edge && rx_thr && !i_standby) begin
          next_dec_state = tbsp_pkg::TBSP_RX_QUAL;
        end
      end
      tbsp_pkg::TBSP_RX_QUAL: begin
        if (i_standby || rx_quiet || !rx_thr || (rx_edge && !long_pulse)) begin
          next_dec_state = tbsp_pkg::TBSP_RX_IDLE;
        end else if (rx_edge && pulses == `TBSP_SQ_LAST) begin
          next_dec_state = tbsp_pkg::TBSP_RX_DATA;
        end
      end
      tbsp_pkg::TBSP_RX_DATA: begin
        if (i_standby || rx_quiet || !rx_thr) begin
          next_dec_state = tbsp_pkg::TBSP_RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dec_state <= tbsp_pkg::TBSP_RX_IDLE;
      line_q    <= 1'b0;
      wcnt      <= '0;
      mcnt      <= '0;
      pulses    <= '0;
    end else begin
      dec_state <= next_dec_state;
      line_q    <= rx_line;
      wcnt      <= rx_edge ? 9'h000 : sat_inc(wcnt);
      mcnt      <= (mid_edge || rx_enter) ? 9'h000 : sat_inc(mcnt);
      if (dec_state != tbsp_pkg::TBSP_RX_QUAL) begin
        pulses <= '0;
      end else if (rx_edge && long_pulse) begin
        pulses <= pulses + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Elastic buffer and recovered clock

  logic       fifo_valid;
  logic [0:0] fifo_data;
  logic [8:0] rcnt;

  wire rx_tick = rcnt == 9'h000;

  tbsp_fifo #(
    .WIDTH (`TBSP_RX_FIFO_W),
    .DEPTH (`TBSP_RX_FIFO_D)
  ) u_rx_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (rx_push),
    .i_data  (rx_line),
    .o_ready (rx_room),
    .i_ready (rx_tick),
    .o_valid (fifo_valid),
    .o_data  (fifo_data)
  );

  // Data and activity change only at the recovered clock fall
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rcnt               <= '0;
      o_receive_clock    <= 1'b0;
      o_receive_data     <= 1'b0;
      o_receive_activity <= 1'b0;
    end else begin
      rcnt <= rx_tick ? BIT_CYC - 9'h001 : rcnt - 9'h001;
      if (rx_tick) begin
        o_receive_clock    <= 1'b0;
        o_receive_activity <= fifo_valid;
        o_receive_data     <= fifo_valid ? fifo_data[0] : o_receive_data;
      end else if (rcnt == HALF_CYC) begin
        o_receive_clock <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Collision

  logic       col_q;
  logic [8:0] cwcnt;
  logic [8:0] chold;

  // The collision pair only feeds this qualifier
  wire col_line  = pair_level(i_aui_collision_pair);
  wire col_edge  = col_line ^ col_q;
  wire col_pulse = col_edge & (cwcnt >= MIN_CYC) & i_aui_col_threshold;
  wire aui_col   = chold != 9'h000;
  wire tp_col    = (tx_active & rx_carrier) | sqe_on | jabbered;
  wire next_col  = ~i_standby & (i_aui_select ? aui_col : tp_col);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      col_q <= 1'b0;
      cwcnt <= '0;
      chold <= '0;
    end else begin
      col_q <= col_line;
      cwcnt <= col_edge ? 9'h000 : sat_inc(cwcnt);
      chold <= col_pulse ? HOLD_CYC : dec_floor(chold);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line outputs and pin control

  logic [1:0] sym_pair;

  assign sym_pair[`TBSP_PAIR_POS] = sym;
  assign sym_pair[`TBSP_PAIR_NEG] = ~sym;

  wire       aui_on       = ~i_standby & i_aui_select;
  wire       tp_on        = ~i_standby & (~i_aui_select | i_auto_select);
  wire [1:0] next_aui_out = ~aui_on ? `TBSP_PAIR_IDLE_HIGH
                          : tx_active ? sym_pair : `TBSP_PAIR_QUIET;
  wire [1:0] next_tp_out  = ~tp_on ? `TBSP_PAIR_IDLE_HIGH
                          : (tx_active & ~i_aui_select) ? sym_pair : `TBSP_PAIR_QUIET;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_aui_transmit_pair        <= `TBSP_PAIR_IDLE_HIGH;
      o_twisted_transmit_pair    <= `TBSP_PAIR_IDLE_HIGH;
      o_collision_indicator      <= 1'b0;
      o_ctrl_oe                  <= 1'b0;
      o_transmit_enable_pulldown <= 1'b0;
    end else begin
      o_aui_transmit_pair        <= next_aui_out;
      o_twisted_transmit_pair    <= next_tp_out;
      o_collision_indicator      <= next_col;
      o_ctrl_oe                  <= ~i_standby;
      o_transmit_enable_pulldown <= ~i_standby;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_first_half;
    enc_state == tbsp_pkg::TBSP_TX_FIRST && tx_mid && !jab_hit;
  endsequence

  sequence s_second_half;
    enc_state == tbsp_pkg::TBSP_TX_SECOND && sym == bit_hold;
  endsequence

  transmit_clock_divide_a: assert property (osc_rise |=> o_transmit_clock != $past(o_transmit_clock))
    else $error("transmit clock missed an oscillator rise");
  transmit_clock_steady_a: assert property (!osc_rise |=> $stable(o_transmit_clock))
    else $error("transmit clock moved without oscillator rise");
  rearm_block_a: assert property (tx_rise && !armed |=> !tx_active)
    else $error("transmit started before re-arm");
  enable_gate_a: assert property (tx_rise && !en_s |=> !tx_active)
    else $error("transmit without enable");
  mid_cell_a: assert property (s_first_half |=> s_second_half ##0 sym != $past(sym))
    else $error("no mid-cell transition");
  encode_bit_a: assert property (tx_start |=> sym == !$past(i_transmit_data))
    else $error("first half-cell not the inverted bit");
  standby_float_a: assert property (i_standby |=> !o_ctrl_oe && !o_transmit_enable_pulldown)
    else $error("controller pins driven in standby");
  pulldown_on_a: assert property (!i_standby |=> o_transmit_enable_pulldown)
    else $error("enable pull-down missing");
  aui_idle_a: assert property (!i_aui_select |=> o_aui_transmit_pair == `TBSP_PAIR_IDLE_HIGH)
    else $error("AUI outputs not idle high");
  tp_idle_a: assert property (i_aui_select && !i_auto_select |=>
                              o_twisted_transmit_pair == `TBSP_PAIR_IDLE_HIGH)
    else $error("TP outputs not idle high");
  tp_overlap_a: assert property (!i_standby && !i_aui_select && tx_active && rx_carrier
                                 |=> o_collision_indicator)
    else $error("TP overlap without collision");
  aui_col_a: assert property (!i_standby && i_aui_select && col_pulse |=> ##1
                              o_collision_indicator [*2])
    else $error("AUI collision not held");
  rx_qual_a: assert property (rx_push |-> dec_state == tbsp_pkg::TBSP_RX_DATA)
    else $error("unqualified data pushed");
  rx_sync_a: assert property ($changed(o_receive_activity) |-> $past(rx_tick))
    else $error("activity moved off the clock fall");
  rx_clock_a: assert property (rx_tick |=> !o_receive_clock ##[12:13] o_receive_clock)
    else $error("recovered clock not symmetric");

endmodule

// File: tenbase_serial_port_if_tb.sv
// Purpose: Self-checking bench of the serial port and its FIFO.
// Assumes: 250 MHz i_clk, 20 MHz oscillator unrelated in phase.
// Notes:   Jabber count shortened to 200 cycles.
module tenbase_serial_port_if_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic sb, aui, auto_s;
    logic [1:0] e_aui, e_tp;
    logic e_oe, e_pd;
  } tbsp_row_t;
  tbsp_row_t rows [5] = '{'{1'h1, 1'h0, 1'h0, 2'h3, 2'h3, 1'h0, 1'h0},
    '{1'h0, 1'h0, 1'h0, 2'h3, 2'h0, 1'h1, 1'h1}, '{1'h0, 1'h0, 1'h1, 2'h3, 2'h0, 1'h1, 1'h1},
    '{1'h0, 1'h1, 1'h0, 2'h0, 2'h3, 1'h1, 1'h1}, '{1'h0, 1'h1, 1'h1, 2'h0, 2'h0, 1'h1, 1'h1}};
  logic       i_clk = 1'h0, i_rst = 1'h1, i_osc = 1'h0, standby = 1'h0, aui_sel = 1'h1;
  logic       auto_sel = 1'h0, hb_en = 1'h0, go = 1'h1, aui_car = 1'h0, col_thr = 1'h0;
  logic       tp_thr = 1'h0, tx_en, tx_data, transmit_clock, rclk, rdata, ract, col, oe, pd;
  logic [1:0] aui_rx = 2'h1, aui_col = 2'h1, tp_rx = 2'h1, aui_tx, tp_tx;
  logic [7:0] pattern = 8'hA5, rx_sr = 8'h00, nbits = 8'h00;
  logic       seen_act = 1'h0, seen_ff = 1'h0;
  int         num_errors = 0, checks = 0, cyc = 0, n, m;

  always #2 i_clk = ~i_clk;
  initial #0.3 forever #25 i_osc = ~i_osc;

  tbsp_port #(.JABBER_CYC(200)) tbsp_port_inst (.i_clk(i_clk), .i_rst(i_rst), .i_osc(i_osc),
    .i_standby(standby), .i_aui_select(aui_sel), .i_auto_select(auto_sel),
    .i_heartbeat_enable(hb_en), .i_transmit_data(tx_data), .i_transmit_enable(tx_en),
    .o_transmit_clock(transmit_clock), .o_receive_clock(rclk), .o_receive_data(rdata),
    .o_receive_activity(ract), .o_collision_indicator(col), .o_ctrl_oe(oe),
    .o_transmit_enable_pulldown(pd), .i_aui_receive_pair(aui_rx), .i_aui_rx_carrier(aui_car),
    .i_aui_collision_pair(aui_col), .i_aui_col_threshold(col_thr),
    .o_aui_transmit_pair(aui_tx), .i_twisted_receive_pair(tp_rx),
    .i_tp_rx_threshold(tp_thr), .o_twisted_transmit_pair(tp_tx));
  tbsp_ctrl_model tbsp_ctrl_model_inst (.i_transmit_clock(transmit_clock), .i_go(go),
    .i_pattern(pattern), .o_transmit_enable(tx_en), .o_transmit_data(tx_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic tx_cells(input int k);
    logic d;
    repeat (k) begin
      @(posedge transmit_clock);
      d = tx_data;
      step(6);
      check("aui_first", 8'(aui_tx), 8'({~d, d}));
      step(12);
      check("aui_second", 8'(aui_tx), 8'({d, ~d}));
    end
  endtask
  task automatic rx_bits(input logic [31:0] bits, input int k);
    for (int i = 0; i < k; i++) begin
      tp_rx = {~bits[i], bits[i]};
      step(12);
      tp_rx = {bits[i], ~bits[i]};
      step(13);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Timeout and line monitors
  always @(posedge i_clk) begin
    cyc++;
    if (col_thr && cyc % 15 == 0) aui_col <= ~aui_col;
    if (ract) seen_act <= 1'h1;
    if (rx_sr == 8'hFF) seen_ff <= 1'h1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  always @(posedge rclk) begin
    if (ract) begin
      rx_sr <= {rx_sr[6:0], rdata};
      nbits <= nbits + 8'h01;
    end
  end

  initial begin
    step(4);
    check("oe_rst", 8'(oe), 8'h0);
    check("aui_rst", 8'(aui_tx), 8'h3);
    step(1);
    i_rst = 1'h0;
    step(3);
    n = 0;
    repeat (600) begin
      step(1);
      if (aui_tx !== 2'h0) n++;
    end
    check("no_rearm", 8'(n), 8'h0);
    go = 1'h0;
    foreach (rows[r]) begin
      {standby, aui_sel, auto_sel} = {rows[r].sb, rows[r].aui, rows[r].auto_s};
      step(6);
      check("aui_idle", 8'(aui_tx), 8'(rows[r].e_aui));
      check("tp_idle", 8'(tp_tx), 8'(rows[r].e_tp));
      check("ctrl_oe", 8'(oe), 8'(rows[r].e_oe));
      check("pulldown", 8'(pd), 8'(rows[r].e_pd));
    end
    auto_sel = 1'h0;
    @(posedge transmit_clock);
    for (n = 0; transmit_clock === 1'h1; n++) step(1);
    for (m = n; transmit_clock === 1'h0; m++) step(1);
    check("transmit_clock_high", 8'(n >= 11 && n <= 14), 8'h1);
    check("transmit_clock_period", 8'(m >= 23 && m <= 26), 8'h1);
    go = 1'h1;
    col_thr = 1'h1;
    @(posedge transmit_clock);
    tx_cells(16);
    check("col_aui", 8'(col), 8'h1);
    col_thr = 1'h0;
    go = 1'h0;
    step(100);
    check("col_aui_end", 8'(col), 8'h0);
    check("aui_no_en", 8'(aui_tx), 8'h0);
    aui_sel = 1'h0;
    go = 1'h1;
    for (n = 0; col !== 1'h1 && n < 600; n++) step(1);
    check("col_jabber", 8'(col === 1'h1 && n >= 190), 8'h1);
    go = 1'h0;
    step(120);
    check("col_jab_end", 8'(col), 8'h0);
    rx_bits(32'h5555, 16);
    tp_rx = 2'h1;
    step(100);
    check("rx_no_thr", 8'(seen_act), 8'h0);
    tp_thr = 1'h1;
    rx_bits(32'h55555555, 32);
    go = 1'h1;
    rx_bits(32'h55, 4);
    check("col_overlap", 8'(col), 8'h1);
    go = 1'h0;
    rx_bits(32'hFF, 8);
    tp_rx = 2'h1;
    step(100);
    check("rx_active", 8'(seen_act), 8'h1);
    check("rx_data", 8'(seen_ff), 8'h1);
    step(300);
    check("rx_idle", 8'(ract), 8'h0);
    // 28 bits follow the four qualifying edges, then 4 and 8 more
    check("rx_count", nbits, 8'h28);
    check("rx_last", rx_sr, 8'hFF);
    hb_en = 1'h1;
    go = 1'h1;
    step(60);
    go = 1'h0;
    for (n = 0; col !== 1'h1 && n < 800; n++) step(1);
    check("col_sqe", 8'(col === 1'h1 && n >= 250 && n <= 400), 8'h1);
    step(300);
    check("col_sqe_end", 8'(col), 8'h0);
    give_verdict();
  end
endmodule
